// ### smcr_pkg.sv
package smcr_pkg;
  // character and message geometry
  localparam int CMD_LEN = 32;          // longest command text
  localparam int MSG_LEN7 = 160;        // seven-bit characters per message
  localparam int MSG_LEN16 = 70;        // two-byte characters per message
  localparam int NUM_LEN = 28;          // longest sender number
  localparam int MAX_CMDS = 10;         // commands per message
  localparam int PW_DIGITS = 4;         // password length
  // word limits
  localparam logic signed [15:0] WORD_MAX = 16'sh7FFF;
  localparam logic signed [15:0] WORD_MIN = 16'sh8000;
  localparam logic [15:0] WORD_RST = 16'h0000;
  // message age units, in minutes
  localparam int AGE_MIN_UNIT = 5;
  localparam int AGE_HALF_HOUR = 30;
  localparam int AGE_DAY = 1440;
  localparam int AGE_WEEK = 10080;
  // age selector codes
  localparam logic [1:0] AGE_MINUTES = 2'h0;
  localparam logic [1:0] AGE_HOURS = 2'h1;
  localparam logic [1:0] AGE_DAYS = 2'h2;
  localparam logic [1:0] AGE_WEEKS = 2'h3;
  // characters
  localparam logic [15:0] CH_DOT = 16'h002E;
  localparam logic [15:0] CH_SPACE = 16'h0020;
  localparam logic [15:0] CH_EQ = 16'h003D;
  localparam logic [15:0] CH_PLUS = 16'h002B;
  localparam logic [15:0] CH_MINUS = 16'h002D;
  localparam logic [15:0] CH_STAR = 16'h002A;
  localparam logic [15:0] CH_ZERO = 16'h0030;
  localparam logic [15:0] CH_NINE = 16'h0039;
endpackage

// ### smcr_buf2.sv
// two-entry skid buffer: a stall by the reader drops nothing
module smcr_buf2 #(
  parameter int WIDTH = 17
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_q [2]; // storage
  logic rd_q, wr_q;            // pointers
  logic [1:0] cnt_q;           // occupancy
  logic [1:0] cnt_d;           // occupancy after this edge
  logic ready_q;               // ready from a flop, so the pin is clean
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  assign in_ready = ready_q;
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = mem_q[rd_q];

  // pointer and count update
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      cnt_q <= 2'd0;
      ready_q <= 1'b1;
    end else begin
      if (push) begin
        mem_q[wr_q] <= in_data;
        wr_q <= ~wr_q;
      end
      if (pop) rd_q <= ~rd_q;
      cnt_q <= cnt_d;
      ready_q <= (cnt_d != 2'd2); // look ahead one edge
    end
  end
endmodule // smcr_buf2

// ### smcr_receiver.sv
// Functional notes
// - notice new message, fetch whole text
// - act only on exact command match; code accepts any command that begins with the text
// - commands up to 32 characters
// - buffer 160 narrow or 70 wide characters
// - word mode one text, bit two
// - configurable maximum message age ranges
// - optional sender number filter, 28 characters
// - optional shared four-digit password
// - reply to sender whenever a command is applied, changed or not
// - retention option preserves outputs
// - clamp value to upper limit
// - clamp value to lower limit
// - switch-on text sets bit
// - switch-off text clears bit
// - clear forces bit low first
// - operate low holds bit
// - load word only on valid value
// - clear zeroes word, operate low holds
// - at most ten dot-separated commands
// - password leads message, then dot
// - earliest command for block wins
module smcr_receiver #(
  parameter int CW = 16,          // character width
  parameter int MSG_DEPTH = smcr_pkg::MSG_LEN7
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // block control pins
  input wire logic operate,
  input wire logic clear,
  // configuration
  input wire logic word_mode,
  input wire logic [smcr_pkg::CMD_LEN*16-1:0] switch_on_text,
  input wire logic [5:0] switch_on_len,
  input wire logic [smcr_pkg::CMD_LEN*16-1:0] switch_off_text,
  input wire logic [5:0] switch_off_len,
  input wire logic [smcr_pkg::CMD_LEN*16-1:0] set_value_text,
  input wire logic [5:0] set_value_len,
  input wire logic [smcr_pkg::NUM_LEN*8-1:0] sender_entity,
  input wire logic [4:0] sender_len,
  input wire logic pw_enable,
  input wire logic [15:0] password_bcd,
  input wire logic ack_enable,
  input wire logic retain_enable,
  input wire logic signed [15:0] upper_limit,
  input wire logic signed [15:0] lower_limit,
  input wire logic [1:0] age_unit,
  input wire logic [7:0] age_count,
  // modem side: message notice and character fetch
  input wire logic msg_notice,
  input wire logic wide_coding,
  input wire logic [31:0] msg_age_minutes,
  input wire logic [smcr_pkg::NUM_LEN*8-1:0] msg_sender,
  input wire logic [4:0] msg_sender_len,
  input wire logic chr_valid,
  output logic chr_ready,
  input wire logic [CW-1:0] chr_data,
  input wire logic chr_last,
  // results
  output logic bit_out,
  output logic signed [15:0] word_out,
  output logic ack_req,
  output logic busy
);
  import smcr_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_FETCH, S_SCAN, S_APPLY} smcr_state_e;

  smcr_state_e state_q;
  logic [CW-1:0] msg_q [MSG_DEPTH]; // fetched text
  logic [7:0] len_q;                // characters fetched
  logic [7:0] idx_q;                // scan position
  logic [7:0] seg_q;                // start of present command
  logic [3:0] ncmd_q;               // commands seen
  logic found_q, hit_on_q, hit_val_q, val_ok_q, neg_q;
  logic signed [17:0] acc_q;        // parsed value, saturating
  logic auth_q;
  logic bit_q;
  logic signed [15:0] word_q;
  logic ack_q, busy_q;

  // skid buffer in front of the message store
  logic bv, br, bl;
  logic [CW-1:0] bd;
  smcr_buf2 #(.WIDTH(CW+1)) u_buf (
    .clk(clk), .rst_b(rst_b),
    .in_valid(chr_valid && state_q == S_FETCH), .in_ready(chr_ready),
    .in_data({chr_last, chr_data}),
    .out_valid(bv), .out_ready(br), .out_data({bl, bd})
  );
  wire [7:0] cap = wide_coding ? 8'(MSG_LEN16) : 8'(MSG_DEPTH);
  assign br = (state_q == S_FETCH);

  // compare text against message at a start position
  function automatic logic text_at(input logic [CMD_LEN*16-1:0] t,
                                   input logic [5:0] n,
                                   input logic [7:0] p);
    logic ok;
    ok = (n != 6'd0) && (({2'b0, n} + p) <= len_q);
    for (int k = 0; k < CMD_LEN; k++) begin
      if (k < n && (8'(k) + p) < 8'(MSG_DEPTH))
        if (msg_q[8'(k) + p] != t[k*16 +: 16]) ok = 1'b0;
    end
    return ok;
  endfunction

  // sender match, trailing star is a wildcard
  function automatic logic num_ok();
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < NUM_LEN; k++) begin
      if (k < sender_len && ok) begin
        if (sender_entity[k*8 +: 8] == CH_STAR[7:0] && k == sender_len - 1)
          return 1'b1;
        if (k >= msg_sender_len ||
            sender_entity[k*8 +: 8] != msg_sender[k*8 +: 8]) ok = 1'b0;
      end
    end
    return ok && (msg_sender_len == sender_len);
  endfunction

  // age ceiling in minutes
  wire [31:0] age_limit =
    age_unit == AGE_MINUTES ? 32'(age_count) * AGE_MIN_UNIT :
    age_unit == AGE_HOURS ? 32'(age_count) * AGE_HALF_HOUR :
    age_unit == AGE_DAYS ? 32'(age_count) * AGE_DAY :
    32'(age_count) * AGE_WEEK;
  wire age_ok = msg_age_minutes <= age_limit;

  // password in first four characters, then dot
  wire pw_ok = !pw_enable || (len_q > 8'd4 &&
    msg_q[0] == 16'(CH_ZERO + password_bcd[15:12]) &&
    msg_q[1] == 16'(CH_ZERO + password_bcd[11:8]) &&
    msg_q[2] == 16'(CH_ZERO + password_bcd[7:4]) &&
    msg_q[3] == 16'(CH_ZERO + password_bcd[3:0]) &&
    msg_q[4] == CH_DOT);

  // current character and its classes
  wire [15:0] cur = (idx_q < len_q) ? 16'(msg_q[idx_q]) : CH_DOT;
  wire at_end = idx_q >= len_q;
  wire is_dig = cur >= CH_ZERO && cur <= CH_NINE;
  wire [3:0] dig = cur[3:0];
  // match only at command start, after skipping blanks
  wire seg_start = (idx_q == seg_q) && cur != CH_SPACE;
  wire m_on = seg_start && text_at(switch_on_text, switch_on_len, idx_q);
  wire m_off = seg_start && text_at(switch_off_text, switch_off_len, idx_q);
  wire m_val = seg_start && text_at(set_value_text, set_value_len, idx_q);
  wire [5:0] val_len = set_value_len;

  // value after clamping
  wire signed [17:0] sv = neg_q ? -acc_q : acc_q;
  wire signed [15:0] clamped =
    sv > 18'(upper_limit) ? upper_limit :
    sv < 18'(lower_limit) ? lower_limit :
    16'(sv);

  // value parser sub-state
  logic in_val_q, seen_eq_q, seen_dig_q;

  // fetch and scan sequence
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
      len_q <= 8'd0;
      idx_q <= 8'd0;
      seg_q <= 8'd0;
      ncmd_q <= 4'd0;
      found_q <= 1'b0;
      hit_on_q <= 1'b0;
      hit_val_q <= 1'b0;
      val_ok_q <= 1'b0;
      neg_q <= 1'b0;
      acc_q <= 18'sd0;
      auth_q <= 1'b0;
      in_val_q <= 1'b0;
      seen_eq_q <= 1'b0;
      seen_dig_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (msg_notice) begin
            state_q <= S_FETCH;
            len_q <= 8'd0;
            busy_q <= 1'b1;
          end
        end
        S_FETCH: begin
          if (bv) begin
            if (len_q < cap) begin
              msg_q[len_q] <= bd;
              len_q <= len_q + 8'd1;
            end
            if (bl) begin // whole text in before scan
              state_q <= S_SCAN;
              idx_q <= 8'd0;
              seg_q <= 8'd0;
              ncmd_q <= 4'd0;
              found_q <= 1'b0;
              in_val_q <= 1'b0;
            end
          end
        end
        S_SCAN: begin
          // password occupies first segment, skip it
          if (idx_q == 8'd0) begin
            auth_q <= pw_ok && age_ok && (sender_len == 5'd0 || num_ok());
          end
          // jump the password so it is never taken for a command
          if (idx_q == 8'd0 && pw_enable) begin
            idx_q <= 8'd5;
            seg_q <= 8'd5;
          end else if (idx_q == seg_q && cur == CH_SPACE && !at_end) begin
            idx_q <= idx_q + 8'd1; // blanks after dot
            seg_q <= seg_q + 8'd1;
          end else if (in_val_q) begin
            if (!seen_eq_q) begin
              if (cur == CH_EQ) seen_eq_q <= 1'b1;
              else if (cur != CH_SPACE) in_val_q <= 1'b0;
            end else if (!seen_dig_q && (cur == CH_MINUS || cur == CH_PLUS)
                         && !neg_q && acc_q == 18'sd0) begin
              neg_q <= (cur == CH_MINUS);
            end else if (is_dig) begin
              seen_dig_q <= 1'b1;
              // one more digit past 13106 would wrap 18 bits: pin it high
              acc_q <= (acc_q > 18'sd13106) ? 18'sd131071
                       : 18'(acc_q * 18'sd10 + 18'(dig));
            end else begin
              // value ends; valid only with a digit
              val_ok_q <= seen_dig_q;
              in_val_q <= 1'b0;
            end
            idx_q <= idx_q + 8'd1;
          end else if (at_end || ncmd_q == 4'(MAX_CMDS)) begin
            state_q <= S_APPLY;
          end else if (!found_q && !word_mode && (m_on || m_off)) begin
            found_q <= 1'b1;
            hit_on_q <= m_on; // on wins on a shared text
            idx_q <= idx_q + 8'd1;
          end else if (!found_q && word_mode && m_val) begin
            found_q <= 1'b1;
            hit_val_q <= 1'b1;
            in_val_q <= 1'b1;
            seen_eq_q <= 1'b0;
            seen_dig_q <= 1'b0;
            neg_q <= 1'b0;
            acc_q <= 18'sd0;
            val_ok_q <= 1'b0;
            idx_q <= idx_q + 8'(val_len);
          end else begin
            if (cur == CH_DOT) begin
              ncmd_q <= ncmd_q + 4'd1;
              seg_q <= idx_q + 8'd1;
            end
            idx_q <= idx_q + 8'd1;
          end
        end
        S_APPLY: begin
          state_q <= S_IDLE;
          busy_q <= 1'b0;
          hit_val_q <= 1'b0;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // decision on output change
  wire act = state_q == S_APPLY && auth_q && found_q && operate && !clear;
  wire set_bit = act && !word_mode;
  wire set_word = act && word_mode && hit_val_q && val_ok_q;

  // outputs; retention is kept by holding through controller reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      if (!retain_enable) begin
        bit_q <= 1'b0;
        word_q <= WORD_RST;
      end
      ack_q <= 1'b0;
    end else begin
      if (clear) begin
        bit_q <= 1'b0;
        word_q <= WORD_RST;
      end else if (!operate) begin
        bit_q <= bit_q;
      end else if (set_bit) begin
        bit_q <= hit_on_q;
      end else if (set_word) begin
        word_q <= clamped;
      end
      ack_q <= ack_enable && (set_bit || set_word);
    end
  end

  assign bit_out = bit_q;
  assign word_out = word_q;
  assign ack_req = ack_q;
  assign busy = busy_q;
endmodule // smcr_receiver

// ### smcr_receiver_monitor.sv
// port-level checker for the message command receiver
module smcr_receiver_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // controls
  input wire logic operate,
  input wire logic clear,
  input wire logic word_mode,
  input wire logic ack_enable,
  input wire logic msg_notice,
  input wire logic signed [15:0] upper_limit,
  input wire logic signed [15:0] lower_limit,
  // results
  input wire logic bit_out,
  input wire logic signed [15:0] word_out,
  input wire logic ack_req,
  input wire logic busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // a settled edge: out of reset and not clearing
  sequence s_calm;
    $past(rst_b) && !$past(clear);
  endsequence
  a_clear_bit_low: assert property (clear && !word_mode |=> !bit_out)
    else $error("bit output not cleared");
  a_clear_word_zero: assert property (clear && word_mode |=> word_out == 0)
    else $error("word output not zeroed");
  a_hold_bit: assert property (!word_mode && !operate && !clear |=> $stable(bit_out))
    else $error("bit output moved while held");
  a_hold_word: assert property (word_mode && !operate && !clear |=> $stable(word_out))
    else $error("word output moved while held");
  a_word_clamped: assert property (s_calm ##0 word_mode && $changed(word_out) |->
    word_out <= upper_limit && word_out >= lower_limit)
    else $error("word output outside limits");
  a_ack_single: assert property (ack_req |-> ack_enable ##1 !ack_req)
    else $error("reply request malformed");
  a_notice_busy: assert property (msg_notice && !busy |=> busy)
    else $error("notice not taken");
  a_change_by_scan: assert property (s_calm ##0
    ($changed(bit_out) || $changed(word_out)) |-> $past(busy))
    else $error("output changed without a message");
endmodule // smcr_receiver_monitor

bind smcr_receiver smcr_receiver_monitor u_smcr_receiver_monitor (
  .clk(clk), .rst_b(rst_b), .operate(operate), .clear(clear),
  .word_mode(word_mode), .ack_enable(ack_enable), .msg_notice(msg_notice),
  .upper_limit(upper_limit), .lower_limit(lower_limit), .bit_out(bit_out),
  .word_out(word_out), .ack_req(ack_req), .busy(busy));

// ### smcr_modem_model.sv
// modem stand-in: announces a message, then streams its characters
module smcr_modem_model (
  // clock
  input wire logic clk,
  // notice and character stream
  output logic msg_notice,
  output logic chr_valid,
  input wire logic chr_ready,
  output logic [15:0] chr_data,
  output logic chr_last
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    msg_notice = 1'b0;
    chr_valid = 1'b0;
    chr_data = 16'h0000;
    chr_last = 1'b0;
  end
  // slow inserts a gap after each character; idle data is inverted
  task automatic send(input string s, input bit slow);
    @(posedge clk);
    msg_notice <= 1'b1;
    @(posedge clk);
    msg_notice <= 1'b0;
    for (int k = 0; k < s.len(); k++) begin
      chr_valid <= 1'b1;
      chr_data <= {8'h00, s[k]};
      chr_last <= (k == s.len() - 1);
      // ready is a register, so its value before the edge is what counts
      do @(negedge clk); while (chr_ready !== 1'b1);
      @(posedge clk);
      if (slow) begin
        chr_valid <= 1'b0;
        chr_data <= ~chr_data;
        @(posedge clk);
      end
    end
    chr_valid <= 1'b0;
    chr_last <= 1'b0;
    chr_data <= ~chr_data;
  endtask
endmodule // smcr_modem_model

// ### smcr_receiver_tb_top.sv
module smcr_receiver_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import smcr_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic operate = 1'b1;
  logic clear = 1'b0;
  logic word_mode = 1'b0;
  logic pw_enable = 1'b0;
  logic ack_enable = 1'b1;
  logic [4:0] sender_len = 5'h00;
  logic [223:0] sender_entity = '0;
  logic [223:0] msg_sender = '0;
  logic [31:0] msg_age_minutes = 32'h0000_0000;
  logic retain_enable = 1'b0;
  logic wide_coding = 1'b0;
  logic [1:0] age_unit = AGE_MINUTES;
  logic [7:0] age_count = 8'hFF;
  logic [4:0] msg_sender_len = 5'h03;
  logic signed [15:0] upper_limit = 16'sh0064;
  logic signed [15:0] lower_limit = 16'shFF9C;
  logic msg_notice, chr_valid, chr_ready, chr_last, bit_out, ack_req, busy;
  logic [15:0] chr_data;
  logic signed [15:0] word_out;
  int error_cnt = 0;
  int compares = 0;
  int ack_n = 0;
  always #12.5 clk = ~clk;
  // count reply requests
  always @(posedge clk) if (ack_req === 1'b1) ack_n++;
  function automatic logic [511:0] p16(input string s);
    p16 = '0;
    for (int k = 0; k < s.len(); k++) p16[16*k+:16] = {8'h00, s[k]};
  endfunction
  function automatic logic [223:0] p8(input string s);
    p8 = '0;
    for (int k = 0; k < s.len(); k++) p8[8*k+:8] = s[k];
  endfunction
  smcr_modem_model u_modem (.clk(clk), .msg_notice(msg_notice),
    .chr_valid(chr_valid), .chr_ready(chr_ready), .chr_data(chr_data),
    .chr_last(chr_last));
  smcr_receiver u_smcr_receiver (.clk(clk), .rst_b(rst_b),
    .operate(operate), .clear(clear), .word_mode(word_mode),
    .switch_on_text(p16("ON")), .switch_on_len(6'h02),
    .switch_off_text(p16("OFF")), .switch_off_len(6'h03),
    .set_value_text(p16("SET")), .set_value_len(6'h03),
    .sender_entity(sender_entity), .sender_len(sender_len),
    .pw_enable(pw_enable), .password_bcd(16'h1443),
    .ack_enable(ack_enable), .retain_enable(retain_enable),
    .upper_limit(upper_limit), .lower_limit(lower_limit),
    .age_unit(age_unit), .age_count(age_count), .msg_notice(msg_notice),
    .wide_coding(wide_coding), .msg_age_minutes(msg_age_minutes),
    .msg_sender(msg_sender), .msg_sender_len(msg_sender_len),
    .chr_valid(chr_valid), .chr_ready(chr_ready), .chr_data(chr_data),
    .chr_last(chr_last), .bit_out(bit_out), .word_out(word_out),
    .ack_req(ack_req), .busy(busy));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one message, then wait (bounded) for the scan to finish
  task automatic msg(input string s, input bit slow);
    int n;
    n = 0;
    u_modem.send(s, slow);
    while (busy !== 1'b0 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (n >= 2000) error_cnt++;
    @(negedge clk);
  endtask
  task automatic t_bit();
    msg("ON", 0); chk(16'(bit_out), 16'h0001);
    chk(16'(ack_n), 16'h0001);
    msg("OFF", 1); chk(16'(bit_out), 16'h0000);
    msg("OFF . ON", 0); chk(16'(bit_out), 16'h0000);
    msg("XON", 0); chk(16'(bit_out), 16'h0000);
    msg("A .ON", 1); chk(16'(bit_out), 16'h0001);
    $display("t_bit done");
  endtask
  task automatic t_hold();
    msg("OFF", 0);
    @(posedge clk) operate <= 1'b0;
    msg("ON", 0); chk(16'(bit_out), 16'h0000);
    @(posedge clk) operate <= 1'b1;
    msg("ON", 0);
    @(posedge clk) clear <= 1'b1;
    msg("ON", 0); chk(16'(bit_out), 16'h0000);
    @(posedge clk) clear <= 1'b0;
    $display("t_hold done");
  endtask
  task automatic t_word();
    @(posedge clk) word_mode <= 1'b1;
    msg("SET=50", 0); chk(word_out, 16'h0032);
    msg("SET=500", 1); chk(word_out, 16'h0064);
    msg("SET=-500", 0); chk(word_out, 16'hFF9C);
    msg("SET=x", 0); chk(word_out, 16'hFF9C);
    msg("SET=200000", 0); chk(word_out, 16'h0064);
    msg("SET=+7", 0); chk(word_out, 16'h0007);
    @(posedge clk) operate <= 1'b0;
    msg("SET=9", 0); chk(word_out, 16'h0007);
    @(posedge clk) clear <= 1'b1;
    @(negedge clk); @(negedge clk); chk(word_out, 16'h0000);
    @(posedge clk) clear <= 1'b0;
    operate <= 1'b1;
    $display("t_word done");
  endtask
  task automatic t_auth();
    @(posedge clk) pw_enable <= 1'b1;
    msg("1111.SET=9", 0); chk(word_out, 16'h0000);
    msg("1443.SET=9", 0); chk(word_out, 16'h0009);
    @(posedge clk) pw_enable <= 1'b0;
    sender_entity <= p8("12*");
    sender_len <= 5'h03;
    msg_sender <= p8("125");
    msg("SET=4", 0); chk(word_out, 16'h0004);
    @(posedge clk) msg_sender <= p8("345");
    msg("SET=5", 0); chk(word_out, 16'h0004);
    @(posedge clk) msg_sender <= p8("125");
    msg_age_minutes <= 32'h0000_1388;
    msg("SET=6", 0); chk(word_out, 16'h0004);
    @(posedge clk) age_unit <= AGE_HOURS;
    msg("SET=6", 0); chk(word_out, 16'h0006);
    $display("t_auth done");
  endtask
  // mid-run reset with and without retention
  task automatic t_keep();
    @(posedge clk) retain_enable <= 1'b1;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk); chk(word_out, 16'h0006);
    @(posedge clk) retain_enable <= 1'b0;
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk); chk(word_out, 16'h0000);
    $display("t_keep done");
  endtask
  // a command past the wide-coding cap must be dropped
  task automatic t_wide();
    string s;
    s = "";
    for (int k = 0; k < MSG_LEN16; k++) s = {s, "X"};
    s = {s, ".SET=3"};
    @(posedge clk) wide_coding <= 1'b1;
    msg(s, 0); chk(word_out, 16'h0000);
    @(posedge clk) wide_coding <= 1'b0;
    msg(s, 0); chk(word_out, 16'h0003);
    $display("t_wide done");
  endtask
  task automatic results();
    $display("compares=%0d error_cnt=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_bit();
    t_hold();
    t_word();
    t_auth();
    t_keep();
    t_wide();
    results();
  end
  // watchdog well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    results();
  end
endmodule // smcr_receiver_tb_top
